// [hdl/overlimit_critical_watchdog_regs.sv]
// Function
// - bus voltage below warning limit sets warning flag, drives warning pin if enabled
// - power above watt limit sets power flag, drives overlimit pin if enabled
// - bus above high limit bits 15-3 sets overvoltage flag and overlimit pin
// - bus below low limit bits 15-3 sets undervoltage flag and overlimit pin
// - overlimit polarity one asserts high, zero asserts low by default
// - overlimit latch one holds the pin, zero follows comparison
// - critical positive limit is unsigned upper byte, 1 mV steps
// - bit seven of critical positive reads the general pin level
// - general pin mode 00/01 high impedance, 10 drives low, 11 high
// - critical polarity bit one makes open-drain critical pin active high
// - hysteresis code steps 2 mV from 0 to 14 mV
// - critical latch one holds the critical pin, zero transparent
// - critical negative limit is unsigned magnitude, negative threshold only
// - filter code gives 0.064 ms steps up to 0.960 ms
// - warning delay code gives 0.1 s steps up to 1.5 s
// - calibration bit zero reads zero, only bits 15-1 used
// - calibration sets full-scale current scaling; power value is taken unscaled
// - current equals shunt reading times calibration divided by 4096
`timescale 1ns/10ps
`default_nettype none
`include "wdog_cfg.svh"

module overlimit_critical_watchdog_regs #(
    parameter int unsigned FILTER_STEP = `FILTER_STEP_CYC,
    parameter int unsigned WARN_STEP   = `WARN_STEP_CYC
) (
    input  wire logic                sys_clk,
    input  wire logic                rst,
    input  wire logic                clk_en,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    output logic      [15:0]         reg_rdata,
    input  wire logic signed [15:0]  shunt_mv,
    input  wire logic signed [15:0]  shunt_reading,
    input  wire logic [15:0]         bus_voltage,
    input  wire logic [15:0]         power_value,
    input  wire logic                warning_pin_enable,
    input  wire logic                overlimit_pin_enable,
    input  wire logic                warning_pin_in,
    output logic                     warning_pin_out,
    output logic                     warning_pin_oe,
    output logic                     overlimit_pin,
    input  wire logic                critical_pin_in,
    output logic                     critical_pin_out,
    output logic                     critical_pin_oe,
    input  wire logic                gpio_in,
    output logic                     gpio_out,
    output logic                     gpio_oe,
    output logic signed [31:0]       current_result,
    output logic      [15:0]         calibration_field
);

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [15:0] bus_low_warning_limit;
    logic [15:0] watt_overlimit_value;
    logic [15:0] bus_high_overlimit_config;
    logic [15:0] bus_low_overlimit_value;
    logic [15:0] critical_positive_limit_config;
    logic [15:0] critical_negative_limit_timing;
    logic [15:0] calibration_value;
    logic [3:0]  status;
    logic [2:0]  gp_sync;

    // general pin input passes three flops; level accepted when second and third agree
    logic gp_level;
    wire  gp_agree = (gp_sync[1] == gp_sync[2]);

    // register writes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bus_low_warning_limit          <= `REG_RESET;
            watt_overlimit_value           <= `REG_RESET;
            bus_high_overlimit_config      <= `REG_RESET;
            bus_low_overlimit_value        <= `REG_RESET;
            critical_positive_limit_config <= `REG_RESET;
            critical_negative_limit_timing <= `REG_RESET;
            calibration_value              <= `REG_RESET;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `ADDR_BUS_LOW_WARN: bus_low_warning_limit <= {reg_wdata[15:3], 3'h0};
                `ADDR_WATT_OL:      watt_overlimit_value <= reg_wdata;
                `ADDR_BUS_HIGH_OL:  bus_high_overlimit_config <= {reg_wdata[15:3], 1'b0, reg_wdata[1:0]};
                `ADDR_BUS_LOW_OL:   bus_low_overlimit_value <= {reg_wdata[15:3], 3'h0};
                `ADDR_CRIT_POS:     critical_positive_limit_config <= {reg_wdata[15:8], 1'b0, reg_wdata[6:0]};
                `ADDR_CRIT_NEG:     critical_negative_limit_timing <= reg_wdata;
                `ADDR_CALIB:        calibration_value <= {reg_wdata[15:1], 1'b0};
                default: ;
            endcase
        end
    end

    // general pin synchroniser and accepted level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            gp_sync  <= 3'h0;
            gp_level <= 1'b0;
        end else if (clk_en) begin
            gp_sync <= {gp_sync[1:0], gpio_in};
            if (gp_agree)
                gp_level <= gp_sync[2];
        end
    end

    // ****************************************************************
    // general pin drive
    // ****************************************************************
    wire [1:0] gp_mode = critical_positive_limit_config[`GP_MODE_MSB:`GP_MODE_LSB];
    assign gpio_oe  = (gp_mode == wdog_pkg::GP_LOW) || (gp_mode == wdog_pkg::GP_HIGH);
    assign gpio_out = (gp_mode == wdog_pkg::GP_HIGH);

    // ****************************************************************
    // over-limit comparisons
    // ****************************************************************
    wire [12:0] bus_v = bus_voltage[`LIM13_MSB:`LIM13_LSB];
    wire cmp_power = power_value > watt_overlimit_value;
    wire cmp_ov    = bus_v > bus_high_overlimit_config[`LIM13_MSB:`LIM13_LSB];
    wire cmp_uv    = bus_v < bus_low_overlimit_value[`LIM13_MSB:`LIM13_LSB];
    wire cmp_warn  = bus_v < bus_low_warning_limit[`LIM13_MSB:`LIM13_LSB];
    wire ol_latch  = bus_high_overlimit_config[`OL_LATCH_BIT];
    wire ol_pol    = bus_high_overlimit_config[`OL_POL_BIT];
    wire status_rd = clk_en && reg_rd && (reg_addr == `ADDR_STATUS);

    // warning delay: condition must persist code*step cycles
    logic [31:0] warn_cnt;
    logic        warn_active;
    wire  [3:0]  wd_code   = critical_negative_limit_timing[3:0];
    wire  [31:0] warn_goal = 32'(wd_code) * 32'(WARN_STEP);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            warn_cnt    <= 32'h0;
            warn_active <= 1'b0;
        end else if (clk_en) begin
            if (!cmp_warn) begin
                warn_cnt    <= 32'h0;
                warn_active <= 1'b0;
            end else if (warn_cnt >= warn_goal) begin
                warn_active <= 1'b1;
            end else begin
                warn_cnt <= warn_cnt + 32'h1;
            end
        end
    end

    // status flags: set wins over clear-on-read; latched flags hold
    wire [3:0] raw_cond = {cmp_uv, cmp_ov, cmp_power, warn_active};
    logic [3:0] ol_hold;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            status  <= 4'h0;
            ol_hold <= 4'h0;
        end else if (clk_en) begin
            status  <= raw_cond | (status_rd ? 4'h0 : status);
            ol_hold <= raw_cond | ((status_rd || !ol_latch) ? 4'h0 : ol_hold);
        end
    end

    // overlimit pin: logic output, polarity selectable
    wire ol_any = overlimit_pin_enable && (|ol_hold[3:1]);
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            overlimit_pin <= 1'b1;
        else if (clk_en)
            overlimit_pin <= ol_pol ? ol_any : !ol_any;
    end

    // warning pin: open collector, active low
    wire warn_assert = warning_pin_enable && ol_hold[`ST_WARN_UV];
    assign warning_pin_out = 1'b0;
    assign warning_pin_oe  = warn_assert;

    // ****************************************************************
    // critical comparator with hysteresis and filter
    // ****************************************************************
    wire [7:0]  crit_pos  = critical_positive_limit_config[15:8];
    wire [7:0]  crit_neg  = critical_negative_limit_timing[15:8];
    wire [4:0]  hyst_mv   = {1'b0, critical_positive_limit_config[3:1], 1'b0};
    wire [3:0]  cf_code   = critical_negative_limit_timing[7:4];
    wire [31:0] filt_goal = 32'(cf_code) * 32'(FILTER_STEP);
    wire crit_latch = critical_positive_limit_config[`CRIT_LATCH_BIT];
    wire crit_pol   = critical_positive_limit_config[`CRIT_POL_BIT];
    logic        crit_trip;
    logic        crit_hold;
    logic [31:0] filt_cnt;
    wire signed [16:0] s = 17'(shunt_mv);
    wire signed [16:0] pos_on  = 17'(crit_pos);
    wire signed [16:0] pos_off = 17'(crit_pos) - 17'(hyst_mv);
    wire signed [16:0] neg_on  = -17'(crit_neg);
    wire signed [16:0] neg_off = -17'(crit_neg) + 17'(hyst_mv);
    wire raw_on  = (s > pos_on) || (s < neg_on);
    wire raw_off = (s <= pos_off) && (s >= neg_off); // no dead band at the limit with zero hysteresis
    logic raw_state;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            raw_state <= 1'b0;
            filt_cnt  <= 32'h0;
            crit_trip <= 1'b0;
            crit_hold <= 1'b0;
        end else if (clk_en) begin
            if (raw_on)
                raw_state <= 1'b1;
            else if (raw_off)
                raw_state <= 1'b0;
            if (raw_state != crit_trip) begin
                if (filt_cnt >= filt_goal) begin
                    crit_trip <= raw_state;
                    filt_cnt  <= 32'h0;
                end else begin
                    filt_cnt <= filt_cnt + 32'h1;
                end
            end else begin
                filt_cnt <= 32'h0;
            end
            crit_hold <= crit_trip | ((status_rd || !crit_latch) ? 1'b0 : crit_hold);
        end
    end
    // open drain: low-active drives low; high-active releases when asserted
    assign critical_pin_out = 1'b0;
    assign critical_pin_oe  = crit_pol ? !crit_hold : crit_hold;

    // ****************************************************************
    // current calculation and read mux
    // ****************************************************************
    assign calibration_field = calibration_value;
    wire signed [32:0] prod = 33'(shunt_reading) * $signed({1'b0, calibration_value[15:1], 1'b0});
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            current_result <= 32'h0;
        else if (clk_en)
            current_result <= 32'(prod >>> `CURRENT_DIV_SHIFT);
    end

    wire [15:0] crit_pos_rd = {critical_positive_limit_config[15:8], gp_level, critical_positive_limit_config[6:0]};
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst)
            reg_rdata <= 16'h0;
        else if (clk_en && reg_rd) begin
            case (reg_addr)
                `ADDR_STATUS:       reg_rdata <= {12'h0, status};
                `ADDR_BUS_LOW_WARN: reg_rdata <= bus_low_warning_limit;
                `ADDR_WATT_OL:      reg_rdata <= watt_overlimit_value;
                `ADDR_BUS_HIGH_OL:  reg_rdata <= bus_high_overlimit_config;
                `ADDR_BUS_LOW_OL:   reg_rdata <= bus_low_overlimit_value;
                `ADDR_CRIT_POS:     reg_rdata <= crit_pos_rd;
                `ADDR_CRIT_NEG:     reg_rdata <= critical_negative_limit_timing;
                `ADDR_CALIB:        reg_rdata <= calibration_value;
                default:            reg_rdata <= 16'h0;
            endcase
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // register fields and general pin
    a_calib_low_zero: assert property (@(posedge sys_clk) disable iff (rst)
        calibration_value[0] == 1'b0) else $error("calibration bit zero set");
    a_gp_mode_drive: assert property (@(posedge sys_clk) disable iff (rst)
        gpio_oe == gp_mode[1]) else $error("general pin drive wrong");
    a_gp_readback: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && gp_agree |=> gp_level == $past(gp_sync[2])) else $error("general pin level not taken");

    // overlimit pin levels
    a_ol_polarity: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && ol_any |=> overlimit_pin == $past(ol_pol)) else $error("overlimit asserted level wrong");
    a_ol_idle_level: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !ol_any |=> overlimit_pin == !$past(ol_pol)) else $error("overlimit idle level wrong");

    // status flags, latch and clear
    a_ol_power_set: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && cmp_power |=> status[`ST_OL_POWER]) else $error("power flag not set");
    a_ol_ov_set: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && cmp_ov |=> status[`ST_OL_OV]) else $error("overvoltage flag not set");
    a_ol_uv_set: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && cmp_uv |=> status[`ST_OL_UV]) else $error("undervoltage flag not set");
    a_status_clear: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && status_rd && raw_cond == 4'h0 |=> status == 4'h0) else $error("status not cleared by read");
    a_ol_transparent: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !ol_latch && !cmp_ov |=> !ol_hold[`ST_OL_OV]) else $error("overlimit held when transparent");
    a_ol_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && ol_latch && ol_hold[`ST_OL_POWER] && !status_rd |=> ol_hold[`ST_OL_POWER])
        else $error("overlimit latch lost");

    // over-limit path: comparison, then flag, then pin
    sequence s_power_over;
        (clk_en && cmp_power) ##1 (clk_en && overlimit_pin_enable && !ol_pol);
    endsequence
    a_ol_pin_assert: assert property (@(posedge sys_clk) disable iff (rst)
        s_power_over |=> !overlimit_pin) else $error("overlimit pin not asserted");

    // warning path: delay count, then flag, then pin
    sequence s_warn_due;
        (clk_en && cmp_warn && warn_cnt >= warn_goal) ##1 clk_en;
    endsequence
    a_warn_due: assert property (@(posedge sys_clk) disable iff (rst)
        s_warn_due |=> warning_pin_oe || !warning_pin_enable) else $error("warning pin late");
    a_warn_early: assert property (@(posedge sys_clk) disable iff (rst)
        !warn_active && warn_cnt < warn_goal |=> !warn_active) else $error("warning flag before its delay");
    a_warn_enable: assert property (@(posedge sys_clk) disable iff (rst)
        !warning_pin_enable |-> !warning_pin_oe) else $error("warning pin driven while disabled");

    // critical comparator filter and latch
    a_crit_filter: assert property (@(posedge sys_clk) disable iff (rst)
        raw_state != crit_trip && filt_cnt < filt_goal |=> $stable(crit_trip))
        else $error("critical output not filtered");
    a_crit_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && crit_latch && crit_hold && !status_rd |=> crit_hold) else $error("critical latch lost");
    a_crit_transparent: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !crit_latch && !crit_trip |=> !crit_hold) else $error("critical held when transparent");

endmodule // overlimit_critical_watchdog_regs
`default_nettype wire

// [common/wdog_cfg.svh]
`ifndef WDOG_CFG_SVH
`define WDOG_CFG_SVH
// register indices on the serial management port
`define ADDR_BUS_LOW_WARN   8'h10
`define ADDR_WATT_OL        8'h11
`define ADDR_BUS_HIGH_OL    8'h12
`define ADDR_BUS_LOW_OL     8'h13
`define ADDR_CRIT_POS       8'h14
`define ADDR_CRIT_NEG       8'h15
`define ADDR_CALIB          8'h16
`define ADDR_STATUS         8'h01
// reset value of every writable field
`define REG_RESET           16'h0000
// field positions
`define LIM13_MSB           15
`define LIM13_LSB           3
`define OL_POL_BIT          1
`define OL_LATCH_BIT        0
`define GP_READ_BIT         7
`define GP_MODE_MSB         6
`define GP_MODE_LSB         5
`define CRIT_POL_BIT        4
`define CRIT_LATCH_BIT      0
// status flag positions (own layout)
`define ST_WARN_UV          0
`define ST_OL_POWER         1
`define ST_OL_OV            2
`define ST_OL_UV            3
// scaling
`define CURRENT_DIV_SHIFT   12
// timing: filter step 0.064 ms, warning step 0.1 s, clock 10 ns
`define FILTER_STEP_NS      64000
`define WARN_STEP_MS        100
`define CLK_PERIOD_NS       10
`define FILTER_STEP_CYC     (`FILTER_STEP_NS / `CLK_PERIOD_NS)
`define WARN_STEP_CYC       (`WARN_STEP_MS * 1000000 / `CLK_PERIOD_NS)
`endif

// [common/wdog_pkg.sv]
package wdog_pkg;
    typedef enum logic [1:0] {
        GP_HIZ_A  = 2'b00,
        GP_HIZ_B  = 2'b01,
        GP_LOW    = 2'b10,
        GP_HIGH   = 2'b11
    } gp_mode_t;
endpackage

// [sim/wdog_host.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// host controller model on the register port
// ****************************************
module wdog_host (
    input  wire logic        sys_clk,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    // idle port: no strobe, address and data unrelated to any access
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'hff;
        reg_wdata = 16'h0000;
    end

    // one write strobe, taken at the rising edge in the middle
    task automatic write_reg(input logic [7:0] addr, input logic [15:0] data);
        @(negedge sys_clk);
        reg_addr  = addr;
        reg_wdata = data;
        reg_wr    = 1'b1;
        @(negedge sys_clk);
        reg_wr    = 1'b0;
        reg_addr  = ~addr;
        reg_wdata = ~data;
    endtask

    // one read strobe, data registered at the taking edge
    task automatic read_reg(input logic [7:0] addr, output logic [15:0] data);
        @(negedge sys_clk);
        reg_addr = addr;
        reg_rd   = 1'b1;
        @(negedge sys_clk);
        reg_rd   = 1'b0;
        reg_addr = ~addr;
        data     = reg_rdata;
    endtask
endmodule // wdog_host
`default_nettype wire

// [sim/overlimit_critical_watchdog_regs_test.sv]
`timescale 1ns/10ps
`default_nettype none
`include "wdog_cfg.svh"
// ****************************************
// bench for the over-limit and critical register bank
// ****************************************
module overlimit_critical_watchdog_regs_test;
    logic               sys_clk, rst, clk_en, reg_wr, reg_rd, ext_gpio, overlimit_pin;
    logic               warning_pin_enable, overlimit_pin_enable, warning_pin_out, warning_pin_oe;
    logic               critical_pin_out, critical_pin_oe, gpio_out, gpio_oe;
    logic        [7:0]  reg_addr;
    logic        [15:0] reg_wdata, reg_rdata, bus_voltage, power_value, calibration_field, rd;
    logic signed [15:0] shunt_mv, shunt_reading;
    logic signed [31:0] current_result;
    int                 error_cnt, total_checks;
    // pin levels seen back by the device: pull-ups on open drains, far source on the gpio
    wire logic          gpio_level = gpio_oe ? gpio_out : ext_gpio;
    wire logic          warn_level = ~warning_pin_oe;
    wire logic          crit_level = ~critical_pin_oe;

    overlimit_critical_watchdog_regs #(.FILTER_STEP(4), .WARN_STEP(10)) dut_u (
        .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .shunt_mv(shunt_mv),
        .shunt_reading(shunt_reading), .bus_voltage(bus_voltage), .power_value(power_value),
        .warning_pin_enable(warning_pin_enable), .overlimit_pin_enable(overlimit_pin_enable),
        .warning_pin_in(warn_level), .warning_pin_out(warning_pin_out), .warning_pin_oe(warning_pin_oe),
        .overlimit_pin(overlimit_pin), .critical_pin_in(crit_level), .critical_pin_out(critical_pin_out),
        .critical_pin_oe(critical_pin_oe), .gpio_in(gpio_level), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .current_result(current_result), .calibration_field(calibration_field));
    wdog_host host_u (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [7:0] addr, input logic [15:0] exp, input string what);
        host_u.read_reg(addr, rd);
        chk_word(what, {16'h0000, exp}, {16'h0000, rd});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        {bus_voltage, power_value, shunt_mv, shunt_reading} = '0;
        {warning_pin_enable, overlimit_pin_enable, ext_gpio} = '0;
        clk_en = 1'b1;
        cyc(2);
        rst = 1'b0;
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // reset values, write masks, unmapped place
    task automatic t_regs();
        logic [15:0] masks [7] = '{16'hfff8, 16'hffff, 16'hfffb, 16'hfff8, 16'hffff, 16'hffff, 16'hfffe};
        do_reset();
        chk_bit("overlimit idle", 1'b1, overlimit_pin);
        chk_bit("gpio oe idle", 1'b0, gpio_oe);
        chk_bit("critical oe idle", 1'b0, critical_pin_oe);
        for (int i = 0; i < 7; i++) rdchk(8'(16 + i), 16'h0000, "reset value");
        clk_en = 1'b0;
        host_u.write_reg(`ADDR_WATT_OL, 16'h1234);
        clk_en = 1'b1;
        rdchk(`ADDR_WATT_OL, 16'h0000, "frozen write");
        for (int i = 0; i < 7; i++) host_u.write_reg(8'(16 + i), 16'hffff);
        host_u.write_reg(8'h20, 16'hffff);
        cyc(5);
        for (int i = 0; i < 7; i++) rdchk(8'(16 + i), masks[i], "write mask");
        rdchk(8'h20, 16'h0000, "unmapped");
    endtask

    // power limit, polarity, transparent and latched pin
    task automatic t_power();
        do_reset();
        overlimit_pin_enable = 1'b1;
        host_u.write_reg(`ADDR_BUS_HIGH_OL, 16'hfff8);
        host_u.write_reg(`ADDR_WATT_OL, 16'h0064);
        power_value = 16'h0064;
        cyc(5);
        chk_bit("power equal", 1'b1, overlimit_pin);
        power_value = 16'h0065;
        cyc(5);
        chk_bit("power over", 1'b0, overlimit_pin);
        rdchk(`ADDR_STATUS, 16'h0002, "power flag");
        power_value = 16'h0010;
        cyc(5);
        chk_bit("transparent", 1'b1, overlimit_pin);
        host_u.write_reg(`ADDR_BUS_HIGH_OL, 16'hfffb);
        cyc(5);
        chk_bit("inverted idle", 1'b0, overlimit_pin);
        power_value = 16'h0065;
        cyc(5);
        chk_bit("inverted over", 1'b1, overlimit_pin);
        power_value = 16'h0010;
        cyc(5);
        chk_bit("latched", 1'b1, overlimit_pin);
        rdchk(`ADDR_STATUS, 16'h0002, "latched flag");
        cyc(5);
        chk_bit("latch cleared", 1'b0, overlimit_pin);
    endtask

    // bus over and under limits on bits 15-3
    task automatic t_bus();
        do_reset();
        overlimit_pin_enable = 1'b1;
        host_u.write_reg(`ADDR_BUS_HIGH_OL, 16'h1000);
        bus_voltage = 16'h1007;
        cyc(5);
        chk_bit("bus equal", 1'b1, overlimit_pin);
        bus_voltage = 16'h1008;
        cyc(5);
        chk_bit("bus over", 1'b0, overlimit_pin);
        rdchk(`ADDR_STATUS, 16'h0004, "over flag");
        do_reset();
        host_u.write_reg(`ADDR_BUS_HIGH_OL, 16'hfff8);
        host_u.write_reg(`ADDR_BUS_LOW_OL, 16'h0800);
        bus_voltage = 16'h07f8;
        cyc(5);
        chk_bit("pin disabled", 1'b1, overlimit_pin);
        rdchk(`ADDR_STATUS, 16'h0008, "under flag");
    endtask

    // warning with a delay of two steps
    task automatic t_warn();
        do_reset();
        warning_pin_enable = 1'b1;
        host_u.write_reg(`ADDR_BUS_HIGH_OL, 16'hfff8);
        host_u.write_reg(`ADDR_CRIT_NEG, 16'h0002);
        host_u.write_reg(`ADDR_BUS_LOW_WARN, 16'h1000);
        bus_voltage = 16'h0ff8;
        cyc(19);
        chk_bit("warning early", 1'b0, warning_pin_oe);
        cyc(3);
        chk_bit("warning due", 1'b1, warning_pin_oe);
        chk_bit("warning drive", 1'b0, warning_pin_out);
        rdchk(`ADDR_STATUS, 16'h0001, "warning flag");
    endtask

    // critical comparator: filter, limits, polarity, latch, hysteresis
    task automatic t_crit();
        logic signed [15:0] mv [6] = '{16'sd20, 16'sd0, -16'sd20, -16'sd10, 16'sd20, 16'sd0};
        logic               oe [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
        do_reset();
        host_u.write_reg(`ADDR_CRIT_POS, 16'h0a00);
        host_u.write_reg(`ADDR_CRIT_NEG, 16'h0a10);
        shunt_mv = 16'sd20;
        cyc(5);
        chk_bit("filter early", 1'b0, critical_pin_oe);
        chk_bit("critical drive", 1'b0, critical_pin_out);
        for (int i = 0; i < 6; i++) begin
            if (i == 4) host_u.write_reg(`ADDR_CRIT_POS, 16'h0a11);
            shunt_mv = mv[i];
            cyc(10);
            chk_bit("critical oe", oe[i], critical_pin_oe);
        end
        host_u.read_reg(`ADDR_STATUS, rd);
        cyc(10);
        chk_bit("critical cleared", 1'b1, critical_pin_oe);
        host_u.write_reg(`ADDR_CRIT_POS, 16'h0a02);
        shunt_mv = 16'sd11;
        cyc(10);
        shunt_mv = 16'sd9;
        cyc(10);
        chk_bit("hysteresis hold", 1'b1, critical_pin_oe);
        shunt_mv = 16'sd7;
        cyc(10);
        chk_bit("hysteresis release", 1'b0, critical_pin_oe);
    endtask

    // every gpio mode, driven level and readback
    task automatic t_gpio();
        logic [1:0] mode;
        do_reset();
        for (int m = 0; m < 4; m++) begin
            mode     = 2'(m);
            ext_gpio = ~mode[0];
            host_u.write_reg(`ADDR_CRIT_POS, {9'h000, mode, 5'h00});
            cyc(5);
            chk_bit("gpio oe", mode[1], gpio_oe);
            if (mode[1]) chk_bit("gpio out", mode[0], gpio_out);
            rdchk(`ADDR_CRIT_POS, {8'h00, mode[1] ? mode[0] : ext_gpio, mode, 5'h00}, "gpio read");
        end
    endtask

    // calibration and current scaling
    task automatic t_current();
        do_reset();
        host_u.write_reg(`ADDR_CALIB, 16'h2001);
        rdchk(`ADDR_CALIB, 16'h2000, "calibration");
        chk_word("calibration field", 32'h00002000, {16'h0000, calibration_field});
        shunt_reading = -16'sd100;
        cyc(4);
        chk_word("current", 32'hffffff38, current_result);
        shunt_reading = -16'sd3;
        cyc(4);
        chk_word("current small", 32'hfffffffa, current_result);
    endtask

    // main sequence
    initial begin
        error_cnt    = 0;
        total_checks = 0;
        t_regs();
        t_power();
        t_bus();
        t_warn();
        t_crit();
        t_gpio();
        t_current();
        close_out();
    end

    // hang guard, far beyond the expected run length
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        close_out();
    end
endmodule // overlimit_critical_watchdog_regs_test
`default_nettype wire
